// >>> logic/mlbm_arbiter.sv
// fixed-rank arbiter over four requesters, lowest rank wins, ties to lower index
// assumes requests and ranks come from logic on the same clock
`timescale 1ns/1ps
module mlbm_arbiter (
    input wire logic [3:0] req_i,
    input wire logic [3:0] allow_i,
    input wire logic [7:0] rank_i,
    output logic valid_o,
    output logic [1:0] idx_o
);
    logic [1:0] best;
    // scan all requesters; a disallowed one never competes
    always_comb begin
        valid_o = 1'b0;
        idx_o = 2'h0;
        best = 2'h3;
        for (int i = 0; i < 4; i++) begin
            if (req_i[i] && allow_i[i] && (!valid_o || rank_i[2*i +: 2] < best)) begin
                valid_o = 1'b1;
                idx_o = 2'(i);
                best = rank_i[2*i +: 2];
            end
        end
    end
endmodule

// >>> logic/mlbm_pkg.sv
// constants of the multi-layer bus matrix: layer and mux indices, address map, priority tables
// assumes one system bus clock and one synchronous reset shared by every layer
// Function
// - code bus decodes only 0x00000000..0x1FFFFFFF; above that it refuses.
// - system bus decodes 0x20000000..0xDFFFFFFF and above 0xE0100000 only.
// - dma layer priority: radio monitor, general dma, crypto, reserved slot.
// - mux one default mac, system, code, dma; alternative dma, mac, system, code.
// - other muxes fixed: two mac/system/code/dma, three mac/dma/system, four, five dma/system.
// - the mac bus layer carries only the radio mac core's transfers.
// - every shared slave is reached only through a mux fed by the layers.
// - peripheral bus mux admits exactly one of its three masters at a time.
// - flash key region open only to general dma with secure channel asserted.
// - flash regions selected by secure-boot configuration are always blocked.
// - other flash and register accesses pass the guard unchanged.
// - cipher key registers are write-only; processor writes are rejected.
package mlbm_pkg;
    localparam int ADDR_W = 32;
    // layer indices
    localparam logic [1:0] L_CODE = 2'h0;
    localparam logic [1:0] L_SYS = 2'h1;
    localparam logic [1:0] L_DMA = 2'h2;
    localparam logic [1:0] L_MAC = 2'h3;
    // dma layer master index of the general dma
    localparam logic [1:0] D_GDMA = 2'h1;
    // mux indices; M_NONE means no slave decodes the address
    localparam logic [2:0] M_ONE = 3'h0;
    localparam logic [2:0] M_TWO = 3'h1;
    localparam logic [2:0] M_THREE = 3'h2;
    localparam logic [2:0] M_FOUR = 3'h3;
    localparam logic [2:0] M_FIVE = 3'h4;
    localparam logic [2:0] M_NONE = 3'h7;
    // layer decode windows
    localparam logic [31:0] CODE_END = 32'h2000_0000;
    localparam logic [31:0] SYS_BASE = 32'h2000_0000;
    localparam logic [31:0] SYS_HOLE_LO = 32'hDFFF_FFFF;
    localparam logic [31:0] SYS_HOLE_HI = 32'hE010_0000;
    // slave map
    localparam logic [31:0] FLASH_END = 32'h0004_0000;
    localparam logic [31:0] EXT_BASE = 32'h1000_0000;
    localparam logic [31:0] EXT_END = 32'h2000_0000;
    localparam logic [31:0] RAM_END = 32'h3000_0000;
    localparam logic [31:0] ROM_END = 32'h4000_0000;
    localparam logic [31:0] REGF_END = 32'h5000_0000;
    localparam logic [31:0] PERI_END = 32'h6000_0000;
    // guarded windows
    localparam logic [31:0] KEY_BASE = 32'h0003_F800;
    localparam logic [31:0] KEY_END = 32'h0004_0000;
    localparam int BOOT_LSB = 16;
    localparam logic [31:0] CKEY_BASE = 32'h4000_0100;
    localparam logic [31:0] CKEY_END = 32'h4000_0120;
    // ranks per layer {mac, dma, sys, code}, 0 is highest; allow masks same order
    localparam logic [7:0] RANK_ONE_DEF = 8'h36;
    localparam logic [7:0] RANK_ONE_ALT = 8'h4B;
    localparam logic [7:0] RANK_TWO = 8'h36;
    localparam logic [7:0] RANK_THREE = 8'h1F;
    localparam logic [7:0] RANK_DS = 8'hC7;
    localparam logic [3:0] ALLOW_ALL = 4'hF;
    localparam logic [3:0] ALLOW_THREE = 4'hE;
    localparam logic [3:0] ALLOW_DS = 4'h6;
    // dma layer ranks {reserved, crypto, gdma, radio monitor}
    localparam logic [7:0] RANK_DMA = 8'hE4;
endpackage

// >>> logic/mlbm_top.sv
// multi-layer bus matrix: four layers, five shared muxes and the flash key guard
// assumes masters hold request and address until ready, and drop or renew it then
`timescale 1ns/1ps
module mlbm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic code_req_i,
    input wire logic [mlbm_pkg::ADDR_W-1:0] code_addr_i,
    input wire logic sys_req_i,
    input wire logic [mlbm_pkg::ADDR_W-1:0] sys_addr_i,
    input wire logic sys_write_i,
    input wire logic mac_req_i,
    input wire logic [mlbm_pkg::ADDR_W-1:0] mac_addr_i,
    input wire logic mac_write_i,
    input wire logic [3:0] dma_req_i,
    input wire logic [3:0][mlbm_pkg::ADDR_W-1:0] dma_addr_i,
    input wire logic [3:0] dma_write_i,
    input wire logic dma_secure_i,
    input wire logic [3:0] lock_i,
    input wire logic [3:0] boot_block_i,
    input wire logic alt_prio_i,
    output logic [3:0] ready_o,
    output logic [3:0] error_o,
    output logic [3:0] dma_grant_o,
    output logic [4:0] slave_sel_o,
    output logic [4:0][1:0] mux_owner_o
);
    import mlbm_pkg::*;

    typedef struct packed {
        logic [3:0] ready;
        logic [3:0] error;
        logic [3:0] dma_gnt;
        logic [4:0] sel;
        logic [4:0][1:0] owner;
        logic [4:0] hold;
        logic alt;
    } mlbm_state_type;

    mlbm_state_type st_r;
    mlbm_state_type st_nxt;
    logic [3:0] dma_mreq;
    logic dma_valid;
    logic [1:0] dma_idx;
    logic [3:0] lreq;
    logic [3:0] fault;
    logic [3:0][2:0] tmux;
    logic [3:0][31:0] laddr;
    logic [3:0] lwr;
    logic lsec;
    logic [4:0][3:0] mreq;
    logic [4:0] mvalid;
    logic [4:0][1:0] midx;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // slave address map to the mux in front of it
    function automatic logic [2:0] slave_mux(input logic [31:0] a);
        if (a < FLASH_END) begin
            slave_mux = M_ONE; // flash controller
        end else if (a >= EXT_BASE && a < RAM_END) begin
            slave_mux = M_TWO; // external memory and ram; bursts may be cut here
        end else if (a < ROM_END && a >= RAM_END) begin
            slave_mux = M_FOUR; // rom
        end else if (a >= ROM_END && a < REGF_END) begin
            slave_mux = M_FIVE; // register file
        end else if (a >= REGF_END && a < PERI_END) begin
            slave_mux = M_THREE; // peripheral bus
        end else begin
            slave_mux = M_NONE;
        end
    endfunction

    function automatic logic [3:0] mux_allow(input logic [2:0] m);
        case (m)
            M_ONE, M_TWO: mux_allow = ALLOW_ALL;
            M_THREE: mux_allow = ALLOW_THREE;
            M_FOUR, M_FIVE: mux_allow = ALLOW_DS;
            default: mux_allow = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] mux_rank(input logic [2:0] m, input logic alt);
        case (m)
            M_ONE: mux_rank = alt ? RANK_ONE_ALT : RANK_ONE_DEF;
            M_TWO: mux_rank = RANK_TWO;
            M_THREE: mux_rank = RANK_THREE;
            default: mux_rank = RANK_DS;
        endcase
    endfunction

    function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_win = (a >= lo) && (a < hi);
    endfunction

    // key guard: only the flash and the cipher key window are gated
    function automatic logic guard_fault(input logic [31:0] a, input logic wr, input logic [1:0] l,
                                         input logic sec, input logic [3:0] blk);
        guard_fault = 1'b0;
        if (in_win(a, KEY_BASE, KEY_END) && !(l == L_DMA && sec)) begin
            guard_fault = 1'b1;
        end
        if (a < FLASH_END && blk[a[BOOT_LSB +: 2]]) begin
            guard_fault = 1'b1;
        end
        if (in_win(a, CKEY_BASE, CKEY_END) && (!wr || l != L_DMA)) begin
            guard_fault = 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // dma layer arbitration

    // the master answered last cycle is masked so a late drop is not served twice
    assign dma_mreq = dma_req_i & ~(st_r.ready[L_DMA] ? st_r.dma_gnt : 4'h0);

    mlbm_arbiter u_dma_arb (
        .req_i(dma_mreq),
        .allow_i(ALLOW_ALL),
        .rank_i(RANK_DMA),
        .valid_o(dma_valid),
        .idx_o(dma_idx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // layer front end: decode, layer windows and guard

    always_comb begin
        lreq = {mac_req_i, dma_valid, sys_req_i, code_req_i} & ~st_r.ready;
        laddr = {mac_addr_i, dma_addr_i[dma_idx], sys_addr_i, code_addr_i};
        lwr = {mac_write_i, dma_write_i[dma_idx], sys_write_i, 1'b0}; // cache never writes
        lsec = dma_secure_i && (dma_idx == D_GDMA);
        for (int l = 0; l < 4; l++) begin
            tmux[l] = slave_mux(laddr[l]);
            fault[l] = lreq[l] && (tmux[l] == M_NONE || !(|(mux_allow(tmux[l]) & (4'h1 << l)))
                       || guard_fault(laddr[l], lwr[l], 2'(l), lsec, boot_block_i));
        end
        fault[L_CODE] = fault[L_CODE] || (lreq[L_CODE] && laddr[L_CODE] >= CODE_END);
        fault[L_SYS] = fault[L_SYS] || (lreq[L_SYS] && (laddr[L_SYS] < SYS_BASE
                       || (laddr[L_SYS] > SYS_HOLE_LO && laddr[L_SYS] <= SYS_HOLE_HI)));
        // the mac port feeds only the mac layer, so no other master can appear there
        for (int m = 0; m < 5; m++) begin
            for (int l = 0; l < 4; l++) begin
                mreq[m][l] = lreq[l] && !fault[l] && tmux[l] == 3'(m);
            end
            if (st_r.hold[m]) begin
                mreq[m] = mreq[m] & (4'h1 << st_r.owner[m]); // locked burst keeps its owner
            end
        end
    end

    for (genvar g = 0; g < 5; g++) begin : g_mux
        mlbm_arbiter u_arb (
            .req_i(mreq[g]),
            .allow_i(mux_allow(3'(g))),
            .rank_i(mux_rank(3'(g), st_r.alt)),
            .valid_o(mvalid[g]),
            .idx_o(midx[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: answers, grants and burst locks

    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = 4'h0;
        st_nxt.error = 4'h0;
        st_nxt.sel = 5'h0;
        st_nxt.alt = alt_prio_i;
        // a refused transfer is answered at once, no slave sees it
        for (int l = 0; l < 4; l++) begin
            if (fault[l]) begin
                st_nxt.ready[l] = 1'b1;
                st_nxt.error[l] = 1'b1;
            end
        end
        // one winner per mux; losers see no ready and keep waiting
        for (int m = 0; m < 5; m++) begin
            if (mvalid[m]) begin
                st_nxt.sel[m] = 1'b1;
                st_nxt.owner[m] = midx[m];
                st_nxt.ready[midx[m]] = 1'b1;
                st_nxt.hold[m] = lock_i[midx[m]] && 3'(m) != M_TWO;
            end else begin
                st_nxt.hold[m] = st_r.hold[m] && lock_i[st_r.owner[m]];
            end
        end
        st_nxt.dma_gnt = st_nxt.ready[L_DMA] ? (4'h1 << dma_idx) : 4'h0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ready_o = st_r.ready;
    assign error_o = st_r.error;
    assign dma_grant_o = st_r.dma_gnt;
    assign slave_sel_o = st_r.sel;
    assign mux_owner_o = st_r.owner;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_mac_code_flash;
        mreq[0][L_MAC] && mreq[0][L_CODE] && !st_r.hold[0] && !st_r.alt;
    endsequence
    // the mac core is a processor too, and like the code bus and the dma layer it can reach flash
    sequence s_mac_key;
        lreq[L_MAC] && in_win(mac_addr_i, KEY_BASE, KEY_END);
    endsequence

    property p_code_range;
        lreq[L_CODE] && code_addr_i >= CODE_END |=> ready_o[L_CODE] && error_o[L_CODE];
    endproperty
    a_code_range: assert property (p_code_range) else $error("code bus decoded above its window");

    property p_sys_range;
        lreq[L_SYS] && sys_addr_i < SYS_BASE |=> error_o[L_SYS] && !(slave_sel_o[0] && mux_owner_o[0] == L_SYS);
    endproperty
    a_sys_range: assert property (p_sys_range) else $error("system bus decoded below its window");

    property p_dma_prio;
        dma_grant_o[1] |-> !$past(dma_mreq[0]);
    endproperty
    a_dma_prio: assert property (p_dma_prio) else $error("general dma beat radio monitor");

    property p_mux_one_def;
        s_mac_code_flash |=> slave_sel_o[0] && mux_owner_o[0] == L_MAC && !ready_o[L_CODE];
    endproperty
    a_mux_one_def: assert property (p_mux_one_def) else $error("mux one default order broken");

    property p_mux_one_alt;
        st_r.alt && mreq[0][L_DMA] && !st_r.hold[0] |=> slave_sel_o[0] && mux_owner_o[0] == L_DMA;
    endproperty
    a_mux_one_alt: assert property (p_mux_one_alt) else $error("mux one alternative order broken");

    property p_mux_three;
        mreq[2][L_MAC] && mreq[2][L_SYS] && !st_r.hold[2] |=> mux_owner_o[2] == L_MAC && !ready_o[L_SYS];
    endproperty
    a_mux_three: assert property (p_mux_three) else $error("peripheral mux order broken");

    property p_stall;
        ready_o[L_SYS] |-> $past(sys_req_i) && !$past(ready_o[L_SYS]);
    endproperty
    a_stall: assert property (p_stall) else $error("ready without a pending request");

    property p_key;
        s_mac_key |=> error_o[L_MAC];
    endproperty
    a_key: assert property (p_key) else $error("processor reached the key region");

    property p_boot;
        lreq[L_CODE] && code_addr_i < FLASH_END && boot_block_i[code_addr_i[BOOT_LSB +: 2]] |=> error_o[L_CODE];
    endproperty
    a_boot: assert property (p_boot) else $error("blocked flash region was reached");

    property p_pass;
        lreq[L_CODE] && code_addr_i < KEY_BASE && !boot_block_i[code_addr_i[BOOT_LSB +: 2]] |=> !error_o[L_CODE];
    endproperty
    a_pass: assert property (p_pass) else $error("plain flash access was gated");

    property p_ckey;
        lreq[L_SYS] && in_win(sys_addr_i, CKEY_BASE, CKEY_END)
            |=> error_o[L_SYS] && !(slave_sel_o[4] && mux_owner_o[4] == L_SYS);
    endproperty
    a_ckey: assert property (p_ckey) else $error("processor touched the cipher key");
endmodule

// >>> verification/mlbm_master.sv
// processor-side master model for one layer of the bus matrix
// assumes the matrix answers with a one-cycle ready pulse, inputs change on the falling edge
`timescale 1ns/1ps
module mlbm_master (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [31:0] addr_i,
    input wire logic write_i,
    input wire logic ready_i,
    output logic req_o,
    output logic [31:0] addr_o,
    output logic write_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // hold request and qualifiers until ready, then release and scramble the address
    initial begin
        req_o = 1'b0;
        addr_o = 32'h0000_0000;
        write_o = 1'b0;
    end
    always @(negedge clk_i) begin
        if (req_o && ready_i) begin
            req_o <= 1'b0;
            addr_o <= ~addr_o; // released lines must not look like a held request
            write_o <= ~write_o;
        end else if (!req_o && go_i) begin
            req_o <= 1'b1;
            addr_o <= addr_i;
            write_o <= write_i;
        end
    end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the multi-layer bus matrix
// assumes mlbm_top and mlbm_pkg compiled first; records the order of answers per run
`timescale 1ns/1ps
module testbench;
    import mlbm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic code_req = 1'b0;
    logic [31:0] code_addr = 32'h0000_0000;
    logic [3:0] dma_req = 4'h0;
    logic [3:0][31:0] dma_addr = '0;
    logic [3:0] dma_write = 4'h0;
    logic dma_secure = 1'b0;
    logic [3:0] boot_block = 4'h0;
    logic alt_prio = 1'b0;
    logic sys_go = 1'b0;
    logic mac_go = 1'b0;
    logic sys_req, sys_write, mac_req, mac_write;
    logic [31:0] sys_addr, mac_addr;
    logic [3:0] ready_o, error_o, dma_grant_o;
    logic [4:0] slave_sel_o;
    logic [4:0][1:0] mux_owner_o;
    logic [31:0] a [4];
    logic [3:0] w = 4'h0;
    logic [3:0] dsel = 4'h2;
    logic [15:0] seq, eseq, dseq;
    logic [4:0] sseen;
    int err_total = 0;
    int checked = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and the two processor masters
    always #25 clk_i = ~clk_i;
    mlbm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .code_req_i(code_req), .code_addr_i(code_addr),
        .sys_req_i(sys_req), .sys_addr_i(sys_addr), .sys_write_i(sys_write), .mac_req_i(mac_req),
        .mac_addr_i(mac_addr), .mac_write_i(mac_write), .dma_req_i(dma_req), .dma_addr_i(dma_addr),
        .dma_write_i(dma_write), .dma_secure_i(dma_secure), .lock_i(4'h0), .boot_block_i(boot_block),
        .alt_prio_i(alt_prio), .ready_o(ready_o), .error_o(error_o), .dma_grant_o(dma_grant_o),
        .slave_sel_o(slave_sel_o), .mux_owner_o(mux_owner_o));
    mlbm_master i_sys (.clk_i(clk_i), .go_i(sys_go), .addr_i(a[1]), .write_i(w[1]),
        .ready_i(ready_o[1]), .req_o(sys_req), .addr_o(sys_addr), .write_o(sys_write));
    mlbm_master i_mac (.clk_i(clk_i), .go_i(mac_go), .addr_i(a[3]), .write_i(w[3]),
        .ready_i(ready_o[3]), .req_o(mac_req), .addr_o(mac_addr), .write_o(mac_write));

    // cache and dma masters release after their answer; only touched when one arrives
    always @(negedge clk_i) begin
        if (ready_o[0]) begin
            code_req <= 1'b0;
            code_addr <= ~code_addr;
        end
        if (dma_grant_o != 4'h0) begin
            dma_req <= dma_req & ~dma_grant_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparison, closing and transfer tasks
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // launch all layers of mask m in one cycle, log answers as nibbles in arrival order
    task automatic go(input logic [3:0] m);
        @(negedge clk_i);
        sys_go <= m[1];
        mac_go <= m[3];
        @(negedge clk_i);
        sys_go <= 1'b0;
        mac_go <= 1'b0;
        code_req <= m[0];
        code_addr <= a[0];
        dma_req <= m[2] ? dsel : 4'h0;
        dma_addr <= {4{a[2]}};
        dma_write <= {4{w[2]}};
        seq = 16'h0000;
        eseq = 16'h0000;
        dseq = 16'h0000;
        sseen = 5'h00;
        repeat (30) begin
            @(posedge clk_i);
            #1;
            sseen = sseen | slave_sel_o; // every slave that saw a transfer
            if (ready_o != 4'h0) begin
                seq = {seq[11:0], ready_o};
                eseq = {eseq[11:0], error_o};
            end
            if (dma_grant_o != 4'h0) begin
                dseq = {dseq[11:0], dma_grant_o};
            end
        end
    endtask

    // one address for every layer in mask m, expecting refusal pattern ee
    task automatic one(input logic [3:0] m, input logic [31:0] ad, input logic wr, input logic [3:0] ee);
        a = '{ad, ad, ad, ad};
        w = {4{wr}};
        go(m);
        check("refusal", eseq, {12'h000, ee});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        a = '{32'h0000_0100, 32'h0000_0200, 32'h0000_0300, 32'h0000_0400};
        repeat (5) @(negedge clk_i);
        check("reset", {ready_o, error_o, dma_grant_o, slave_sel_o[3:0]}, 16'h0000);
        @(negedge clk_i);
        rst_i <= 1'b0;
        // flash mux, default order; system layer refused below its window
        go(4'hF);
        check("mux one default", seq, 16'h0A14);
        check("system low refused", eseq, 16'h0200);
        check("flash select", 16'(sseen), 16'h0001);
        check("flash owner", 16'(mux_owner_o[0]), 16'(L_DMA));
        @(negedge clk_i);
        alt_prio <= 1'b1;
        go(4'hF);
        check("mux one alternative", seq, 16'h0681);
        @(negedge clk_i);
        alt_prio <= 1'b0;
        // ram and external memory share mux two
        a = '{32'h1000_0000, 32'h2000_0000, 32'h2000_0010, 32'h2000_0020};
        go(4'hF);
        check("mux two order", seq, 16'h8214);
        check("mux two stall", eseq, 16'h0000);
        check("mux two select", 16'(sseen), 16'h0002);
        a = '{32'h0, 32'h5000_0000, 32'h5000_0000, 32'h5000_0000};
        go(4'hE);
        check("mux three order", seq, 16'h0842);
        check("peripheral owner", 16'(mux_owner_o[2]), 16'(L_SYS));
        check("peripheral select", 16'(sseen), 16'h0004);
        a = '{32'h0, 32'h4000_0000, 32'h4000_0000, 32'h0};
        go(4'h6);
        check("mux five order", seq, 16'h0042);
        check("register file select", 16'(sseen), 16'h0010);
        a = '{32'h0, 32'h0, 32'h3000_0000, 32'h0};
        dsel = 4'hF;
        go(4'h4);
        check("dma layer order", dseq, 16'h1248);
        check("rom select", 16'(sseen), 16'h0008);
        dsel = 4'h2;
        // decode windows, unmapped space and the guard
        one(4'h1, 32'h2000_0000, 1'b0, 4'h1);
        one(4'h1, 32'h1FFF_FFF0, 1'b0, 4'h0);
        one(4'h2, 32'hE000_0000, 1'b0, 4'h2);
        one(4'h2, 32'h6000_0000, 1'b0, 4'h2);
        one(4'h4, 32'h0003_F800, 1'b0, 4'h4);
        @(negedge clk_i);
        dma_secure <= 1'b1;
        one(4'h4, 32'h0003_FFFC, 1'b0, 4'h0);
        one(4'h8, 32'h0003_F800, 1'b0, 4'h8);
        @(negedge clk_i);
        boot_block <= 4'h2;
        // cache and dma layer together, so the code bus meets a blocked and an open region too
        one(4'h5, 32'h0001_0000, 1'b0, 4'h5);
        one(4'h5, 32'h0002_0000, 1'b0, 4'h0);
        one(4'h2, 32'h4000_0100, 1'b1, 4'h2);
        one(4'h4, 32'h4000_011C, 1'b1, 4'h0);
        one(4'h4, 32'h4000_0100, 1'b0, 4'h4);
        one(4'h8, 32'h2000_0040, 1'b1, 4'h0);
        stop_test();
    end

    // hang guard: the runs above need well under a thousand cycles
    initial begin
        #(5000 * 50);
        err_total++;
        stop_test();
    end
endmodule
